// [design/sram_ctrl_pkg.sv]
// Package with timing constants and request types for the SRAM pin controller
package sram_ctrl_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	// Device times in ns, as printed
	localparam int READ_CYCLE_MIN_NS = 45;
	localparam int ADDR_TO_VALID_MAX_NS = 45;
	localparam int GATE_TO_VALID_MAX_NS = 22;
	localparam int GATE_OFF_TO_FLOAT_NS = 18;
	localparam int DESELECT_TO_FLOAT_NS = 18;
	localparam int WRITE_CYCLE_MIN_NS = 45;
	localparam int SELECT_TO_WRITE_END_NS = 35;
	localparam int ADDR_SETUP_WRITE_END_NS = 35;
	localparam int STROBE_PULSE_MIN_NS = 35;
	localparam int DATA_SETUP_WRITE_END_NS = 25;
	localparam int DATA_HOLD_WRITE_END_NS = 0;
	localparam int ADDR_HOLD_WRITE_END_NS = 0;
	localparam int ADDR_SETUP_WRITE_START_NS = 0;
	localparam int STROBE_LOW_TO_FLOAT_NS = 18;
	// Cycle counts, minima rounded up, at least one cycle
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int STROBE_CYC = cyc_up(
		(STROBE_PULSE_MIN_NS > STROBE_LOW_TO_FLOAT_NS + DATA_SETUP_WRITE_END_NS) ?
		STROBE_PULSE_MIN_NS : STROBE_LOW_TO_FLOAT_NS + DATA_SETUP_WRITE_END_NS);
	localparam int WRITE_CYC = cyc_up(WRITE_CYCLE_MIN_NS);
	localparam int READ_CYC = cyc_up(READ_CYCLE_MIN_NS);
	// Sample point covers the slowest of address, select and gate paths
	localparam int READ_SAMPLE_CYC = cyc_up(ADDR_TO_VALID_MAX_NS) + 2;
	localparam int FLOAT_CYC = cyc_up(
		(GATE_OFF_TO_FLOAT_NS > DESELECT_TO_FLOAT_NS) ?
		GATE_OFF_TO_FLOAT_NS : DESELECT_TO_FLOAT_NS);
	localparam int CNT_W = 8;
	// User request bundle
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} req_t;
	// Pin strobes bundle, select_low_active active low
	typedef struct packed {
		logic select_low_active;
		logic select_high_active;
		logic write_strobe_n;
		logic out_gate_n;
	} pins_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WSTROBE = 3'b001,
		ST_WREC = 3'b010,
		ST_RACC = 3'b011,
		ST_RFLOAT = 3'b100
	} state_t;
endpackage

// [design/sram_sync2.sv]
// Two flip-flop synchroniser for bus input pins
`timescale 1ns/1ps
`default_nettype none
module sram_sync2 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Data
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_ff;
	// First stage feeds only the second stage
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			meta_ff <= '0;
			q_out <= '0;
		end
		else
		begin
			meta_ff <= d_in;
			q_out <= meta_ff;
		end
	end
endmodule // sram_sync2
`default_nettype wire

// [design/sram_ctrl.sv]
// Host-side controller driving an asynchronous 128K x 8 static RAM
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl #(
	parameter int ADDR_W = sram_ctrl_pkg::ADDR_W,
	parameter int DATA_W = sram_ctrl_pkg::DATA_W
) (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RSTN_IN,
	// User request port
	input wire logic REQ_VALID_IN,
	input wire sram_ctrl_pkg::req_t REQ_IN,
	output logic REQ_READY_OUT,
	output logic RDATA_VALID_OUT,
	output logic [DATA_W-1:0] RDATA_OUT,
	output logic WDONE_OUT,
	// SRAM pins
	output logic [ADDR_W-1:0] SRAM_ADDR_OUT,
	output sram_ctrl_pkg::pins_t SRAM_PINS_OUT,
	input wire logic [DATA_W-1:0] SRAM_DQ_IN,
	output logic [DATA_W-1:0] SRAM_DQ_OUT,
	output logic [DATA_W-1:0] SRAM_DQ_OE_N_OUT
);
	// Widths are fixed by the request struct, so other values cannot be served
	if (ADDR_W != sram_ctrl_pkg::ADDR_W || DATA_W != sram_ctrl_pkg::DATA_W)
	begin : g_width_check
		$error("sram_ctrl widths must match the request struct");
	end
	// Counts must fit the 8-bit counter; a recovery of zero cycles would hang
	if (sram_ctrl_pkg::CNT_W != 8 || sram_ctrl_pkg::STROBE_CYC > 255
		|| sram_ctrl_pkg::READ_SAMPLE_CYC > 255 || sram_ctrl_pkg::FLOAT_CYC > 255
		|| sram_ctrl_pkg::WRITE_CYC <= sram_ctrl_pkg::STROBE_CYC)
	begin : g_count_check
		$error("sram_ctrl cycle counts do not fit the sequencer");
	end

	localparam logic [7:0] STROBE_CYC = 8'(sram_ctrl_pkg::STROBE_CYC);
	localparam logic [7:0] WREC_CYC =
		8'(sram_ctrl_pkg::WRITE_CYC - sram_ctrl_pkg::STROBE_CYC);
	localparam logic [7:0] RSAMPLE_CYC = 8'(sram_ctrl_pkg::READ_SAMPLE_CYC);
	localparam logic [7:0] FLOAT_CYC = 8'(sram_ctrl_pkg::FLOAT_CYC);

	sram_ctrl_pkg::state_t state_ff;
	sram_ctrl_pkg::state_t nxt_state;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic [DATA_W-1:0] dq_sync;
	logic cnt_done;

	// Read data pins come from another timing domain
	sram_sync2 #(
		.WIDTH(DATA_W)
	) u_dq_sync (
		.clk_in(CLK_SYS_IN),
		.rstn_in(RSTN_IN),
		.d_in(SRAM_DQ_IN),
		.q_out(dq_sync)
	);

	assign cnt_done = (cnt_ff == 8'h01);

	// Sequencing of every pin transition through fixed cycle counts
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = (cnt_ff > 8'h00) ? cnt_ff - 8'h01 : 8'h00;
		case (state_ff)
			sram_ctrl_pkg::ST_IDLE:
			begin
				// Ready gates the take, so the first cycle after reset refuses
				if (REQ_VALID_IN && REQ_READY_OUT)
				begin
					nxt_state = REQ_IN.write ? sram_ctrl_pkg::ST_WSTROBE
						: sram_ctrl_pkg::ST_RACC;
					nxt_cnt = REQ_IN.write ? STROBE_CYC : RSAMPLE_CYC;
				end
			end
			sram_ctrl_pkg::ST_WSTROBE:
			begin
				if (cnt_done)
				begin
					// Strobe and select release on the same edge, so both end the write
					nxt_state = sram_ctrl_pkg::ST_WREC;
					nxt_cnt = WREC_CYC;
				end
			end
			sram_ctrl_pkg::ST_WREC:
			begin
				if (cnt_done)
					nxt_state = sram_ctrl_pkg::ST_IDLE;
			end
			sram_ctrl_pkg::ST_RACC:
			begin
				if (cnt_done)
				begin
					nxt_state = sram_ctrl_pkg::ST_RFLOAT;
					nxt_cnt = FLOAT_CYC;
				end
			end
			sram_ctrl_pkg::ST_RFLOAT:
			begin
				// Device float time bounds bus turnaround
				if (cnt_done)
					nxt_state = sram_ctrl_pkg::ST_IDLE;
			end
			default:
			begin
				nxt_state = sram_ctrl_pkg::ST_IDLE;
				nxt_cnt = 8'h00;
			end
		endcase
	end

	// State and counter
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			state_ff <= sram_ctrl_pkg::ST_IDLE;
			cnt_ff <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// Address and write data latched at request, held through recovery
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			SRAM_ADDR_OUT <= '0;
			SRAM_DQ_OUT <= '0;
		end
		else if (state_ff == sram_ctrl_pkg::ST_IDLE && REQ_VALID_IN && REQ_READY_OUT)
		begin
			SRAM_ADDR_OUT <= REQ_IN.addr;
			SRAM_DQ_OUT <= REQ_IN.wdata;
		end
	end

	// Select, strobe and gate levels; select stays on through the strobe
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			SRAM_PINS_OUT.select_low_active <= 1'b1;
			SRAM_PINS_OUT.select_high_active <= 1'b0;
			SRAM_PINS_OUT.write_strobe_n <= 1'b1;
			SRAM_PINS_OUT.out_gate_n <= 1'b1;
		end
		else
		begin
			// Selected in write strobe and read access only
			SRAM_PINS_OUT.select_low_active <= !(nxt_state == sram_ctrl_pkg::ST_WSTROBE
				|| nxt_state == sram_ctrl_pkg::ST_RACC);
			SRAM_PINS_OUT.select_high_active <= (nxt_state == sram_ctrl_pkg::ST_WSTROBE
				|| nxt_state == sram_ctrl_pkg::ST_RACC);
			// Strobe pulse spans float plus setup, also covering 35 ns
			SRAM_PINS_OUT.write_strobe_n <=
				!(nxt_state == sram_ctrl_pkg::ST_WSTROBE);
			// Gate kept high during writes so the device never drives
			SRAM_PINS_OUT.out_gate_n <= !(nxt_state == sram_ctrl_pkg::ST_RACC);
		end
	end

	// Own drivers on only in the write strobe; they release on the same edge that ends it
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			SRAM_DQ_OE_N_OUT <= '1;
		else if (nxt_state == sram_ctrl_pkg::ST_WSTROBE)
			SRAM_DQ_OE_N_OUT <= '0;
		else
			SRAM_DQ_OE_N_OUT <= '1;
	end

	// Read capture at the end of the access window, after synchroniser delay
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			RDATA_OUT <= '0;
			RDATA_VALID_OUT <= 1'b0;
			WDONE_OUT <= 1'b0;
			REQ_READY_OUT <= 1'b0;
		end
		else
		begin
			RDATA_VALID_OUT <= (state_ff == sram_ctrl_pkg::ST_RACC) && cnt_done;
			if ((state_ff == sram_ctrl_pkg::ST_RACC) && cnt_done)
				RDATA_OUT <= dq_sync;
			WDONE_OUT <= (state_ff == sram_ctrl_pkg::ST_WREC) && cnt_done;
			REQ_READY_OUT <= (nxt_state == sram_ctrl_pkg::ST_IDLE);
		end
	end
endmodule // sram_ctrl
`default_nettype wire

// [testbench/sram_ctrl_props.sv]
// Checker for the SRAM pin controller timing
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_props #(
	parameter int ADDR_W = sram_ctrl_pkg::ADDR_W,
	parameter int DATA_W = sram_ctrl_pkg::DATA_W
) (
	// Clock, reset and user side
	input wire logic CLK_SYS_IN,
	input wire logic RSTN_IN,
	input wire logic REQ_VALID_IN,
	input wire sram_ctrl_pkg::req_t REQ_IN,
	input wire logic REQ_READY_OUT,
	input wire logic RDATA_VALID_OUT,
	input wire logic WDONE_OUT,
	// Pin side
	input wire logic [ADDR_W-1:0] SRAM_ADDR_OUT,
	input wire sram_ctrl_pkg::pins_t SRAM_PINS_OUT,
	input wire logic [DATA_W-1:0] SRAM_DQ_OUT,
	input wire logic [DATA_W-1:0] SRAM_DQ_OE_N_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RSTN_IN);
	// Request taken and pin shorthands
	wire logic take = REQ_VALID_IN && REQ_READY_OUT;
	wire logic we_n = SRAM_PINS_OUT.write_strobe_n;
	wire logic gate_n = SRAM_PINS_OUT.out_gate_n;
	// Strobe of 11 cycles covers float plus setup even with gate low
	sequence strobe_held;
		!we_n [*8] ##1 !we_n [*3] ##1 we_n;
	endsequence
	// Gate low 14 cycles: access time plus two sync stages
	sequence gate_held;
		!gate_n [*8] ##1 !gate_n [*6] ##1 gate_n;
	endsequence
	// Busy span checked is 11 cycles, one short of the 12-cycle write
	sequence busy_span;
		!REQ_READY_OUT [*8] ##1 !REQ_READY_OUT [*3];
	endsequence
	strobe_len_a: assert property (take && REQ_IN.write |=> strobe_held)
		else $error("write strobe width wrong");
	gate_len_a: assert property (take && !REQ_IN.write |=> gate_held)
		else $error("read gate width wrong");
	cycle_min_a: assert property (take |=> busy_span)
		else $error("cycle shorter than minimum");
	write_done_a: assert property (take && REQ_IN.write |-> ##13 WDONE_OUT)
		else $error("write done late or early");
	read_done_a: assert property (take && !REQ_IN.write |-> ##15 RDATA_VALID_OUT)
		else $error("read data valid late or early");
	strobe_sel_a: assert property (!we_n |->
		!SRAM_PINS_OUT.select_low_active && SRAM_PINS_OUT.select_high_active)
		else $error("strobe low without select");
	strobe_drive_a: assert property (!we_n |-> SRAM_DQ_OE_N_OUT == '0 && gate_n)
		else $error("data not driven during strobe");
	gate_float_a: assert property (!gate_n |-> &SRAM_DQ_OE_N_OUT)
		else $error("bus driven while gate low");
	write_hold_a: assert property (!we_n && $past(!we_n) |->
		$stable(SRAM_ADDR_OUT) && $stable(SRAM_DQ_OUT))
		else $error("address or data moved in write");
	end_edge_a: assert property ($rose(we_n) |->
		$stable(SRAM_ADDR_OUT) && $stable(SRAM_DQ_OUT))
		else $error("address or data moved at write end");
endmodule // sram_ctrl_props
bind sram_ctrl sram_ctrl_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) props (
	.CLK_SYS_IN, .RSTN_IN, .REQ_VALID_IN, .REQ_IN, .REQ_READY_OUT, .RDATA_VALID_OUT,
	.WDONE_OUT, .SRAM_ADDR_OUT, .SRAM_PINS_OUT, .SRAM_DQ_OUT, .SRAM_DQ_OE_N_OUT
);
`default_nettype wire

// [testbench/sram_dev.sv]
// Behavioural model of the asynchronous 128K x 8 memory
`timescale 1ns/1ps
`default_nettype none
module sram_dev #(
	parameter int ACC_NS = 45
) (
	// Pins from the controller
	input wire logic [16:0] addr_in,
	input wire sram_ctrl_pkg::pins_t pins_in,
	input wire logic [7:0] bus_in,
	// Data the memory puts on the bus
	output logic [7:0] dq_out
);
	logic [7:0] mem [0:131071];
	logic [7:0] last = 8'h00;
	wire logic [7:0] bus_d;
	wire logic [16:0] addr_d;
	// Combined select; deselect is also sleep, waking at once
	wire logic sel = !pins_in.select_low_active && pins_in.select_high_active;
	wire logic wr = sel && !pins_in.write_strobe_n;
	wire logic rd = sel && pins_in.write_strobe_n && !pins_in.out_gate_n;
	// Look 1 ns back so a release at the ending edge cannot race the capture
	assign #1 bus_d = bus_in;
	assign #1 addr_d = addr_in;
	// Store at whichever edge ends the overlap
	always @(negedge wr)
		mem[addr_d] = bus_d;
	// Slow answer; when not reading, a scrambled level instead of the old byte
	always @(rd or addr_in)
	begin
		dq_out = ~last;
		if (rd)
		begin
			#(ACC_NS) dq_out = mem[addr_in];
			last = dq_out;
		end
	end
endmodule // sram_dev
`default_nettype wire

// [testbench/sram_ctrl_test.sv]
// Testbench for the SRAM pin controller with a behavioural memory
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_test;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic valid = 1'b0;
	sram_ctrl_pkg::req_t req = '0;
	logic ready, rvalid, wdone;
	logic [7:0] rdata, ctrl_dq, oe_n, dev_dq, bus;
	logic [16:0] addr;
	sram_ctrl_pkg::pins_t pins;
	int err_count = 0;
	int total_checks = 0;
	// Bus level: controller bit where enabled, else the memory
	assign bus = (~oe_n & ctrl_dq) | (oe_n & dev_dq);
	always #2 clk = ~clk;
	sram_ctrl dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .REQ_VALID_IN(valid), .REQ_IN(req),
		.REQ_READY_OUT(ready), .RDATA_VALID_OUT(rvalid), .RDATA_OUT(rdata), .WDONE_OUT(wdone),
		.SRAM_ADDR_OUT(addr), .SRAM_PINS_OUT(pins), .SRAM_DQ_IN(bus), .SRAM_DQ_OUT(ctrl_dq),
		.SRAM_DQ_OE_N_OUT(oe_n));
	sram_dev mem (.addr_in(addr), .pins_in(pins), .bus_in(bus), .dq_out(dev_dq));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp)
		begin
			err_count = err_count + 1;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One request; both kinds check answer time, reads the byte too
	task automatic op(input logic w, input logic [16:0] a, input logic [7:0] d);
		logic [31:0] n;
		n = 32'h00000001;
		while (ready !== 1'b1)
			@(negedge clk);
		valid = 1'b1;
		req = '{w, a, d};
		@(negedge clk);
		valid = 1'b0;
		while ((w ? wdone : rvalid) !== 1'b1 && n < 32'h00000028)
		begin
			@(negedge clk);
			n = n + 32'h00000001;
		end
		// A pulse launched k edges after the take shows here with n at k plus one
		check(n, w ? 32'(sram_ctrl_pkg::WRITE_CYC + 1)
			: 32'(sram_ctrl_pkg::READ_SAMPLE_CYC + 1));
		if (!w)
			check(32'(rdata), 32'(d));
	endtask
	// Pins idle and deselected in reset
	task automatic t_reset;
		check(32'(pins), 32'h0000000b);
		check(32'(oe_n), 32'h000000ff);
		check(32'(ready), 32'h0);
	endtask
	// Address extremes written and read back
	task automatic t_write_read;
		op(1'b1, 17'h00000, 8'h5a);
		op(1'b1, 17'h1ffff, 8'ha5);
		op(1'b0, 17'h00000, 8'h5a);
		op(1'b0, 17'h1ffff, 8'ha5);
	endtask
	// Read to write to read back to back; read data holds across a write
	task automatic t_turnaround;
		op(1'b0, 17'h1ffff, 8'ha5);
		op(1'b1, 17'h1ffff, 8'h3c);
		check(32'(rdata), 32'h000000a5);
		op(1'b0, 17'h1ffff, 8'h3c);
	endtask
	initial
	begin
		repeat (3) @(negedge clk);
		t_reset();
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		t_write_read();
		t_turnaround();
		end_sim();
	end
	// Watchdog well beyond seven operations of about 20 cycles
	initial
	begin
		#20000;
		err_count = err_count + 1;
		end_sim();
	end
endmodule // sram_ctrl_test
`default_nettype wire
